// ===== design/spei_mem_if.sv
// Purpose: Setpoint store ports
// Assumes: Registered reads
// Notes: Used for store and mirror
`timescale 1ns/1ps
`default_nettype none
interface spei_mem_if;
  import spei_pkg::*;
  logic we;
  logic [IDX_W-1:0] waddr;
  logic [VAL_W-1:0] wdata;
  logic [IDX_W-1:0] raddr_a;
  logic [VAL_W-1:0] rdata_a;
  logic [IDX_W-1:0] raddr_b;
  logic [VAL_W-1:0] rdata_b;
  modport mem (input we, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
  modport user (output we, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
endinterface : spei_mem_if
`default_nettype wire

// ===== design/spei_pkg.sv
// Purpose: Shared constants
// Assumes: 25 MHz clock
// Notes: Values in signed millivolts
package spei_pkg;
  // Timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned HOLD_ACCEL_MS = 2000;
  localparam int unsigned REPEAT_SLOW_MS = 250;
  localparam int unsigned REPEAT_FAST_MS = 10;
  localparam int unsigned SEGTEST_MS = 1000;
  localparam int unsigned HOLD_ACCEL_CYC = HOLD_ACCEL_MS * CYC_PER_MS;
  localparam int unsigned REPEAT_SLOW_CYC = REPEAT_SLOW_MS * CYC_PER_MS;
  localparam int unsigned REPEAT_FAST_CYC = REPEAT_FAST_MS * CYC_PER_MS;
  localparam int unsigned SEGTEST_CYC = SEGTEST_MS * CYC_PER_MS;

  // Storage geometry
  localparam int unsigned NUM_LOC = 100;
  localparam int unsigned IDX_W = 7;
  localparam int unsigned VAL_W = 16;
  localparam logic [IDX_W-1:0] IDX_MIN = 7'h00;
  localparam logic [IDX_W-1:0] IDX_MAX = 7'h63;

  // Millivolt values
  localparam logic signed [VAL_W-1:0] MV_FSH = 16'sh2710;
  localparam logic signed [VAL_W-1:0] MV_ZERO = 16'sh0000;
  localparam logic signed [VAL_W-1:0] MV_FSL = -16'sh2710;
  localparam logic signed [VAL_W-1:0] MV_SEGTEST = 16'sh1388;
  localparam logic signed [VAL_W-1:0] MV_STEP = 16'sh0001;
  localparam logic [3:0] DIGIT_EIGHT = 4'h8;

  // Selector positions
  localparam logic [3:0] SEL_OFF = 4'h0;
  localparam logic [3:0] SEL_READ = 4'h1;
  localparam logic [3:0] SEL_SET = 4'h2;
  localparam logic [3:0] SEL_FSH = 4'h3;
  localparam logic [3:0] SEL_ZERO = 4'h4;
  localparam logic [3:0] SEL_FSL = 4'h5;
  localparam logic [3:0] SEL_GAIN = 4'h7;
  localparam logic [3:0] SEL_OFFS = 4'h8;
  localparam logic [3:0] SEL_CAL = 4'h9;

  // Channels and serial word
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned DAC_BITS = 16;
  localparam logic [4:0] DAC_LAST = 5'h0F;

  // Register map
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_TRIP = 8'h08;
  localparam int unsigned CTRL_CAL_BIT = 4;
  localparam logic [NUM_CH-1:0] CTRL_POL_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Serializer states
  typedef enum logic [0:0] {
    SER_IDLE = 1'b0,
    SER_SHIFT = 1'b1
  } spei_ser_type;
endpackage : spei_pkg

// ===== design/spei_store.sv
// Purpose: Setpoint store
// Assumes: Synchronous write
// Notes: Contents are not reset, as with a real memory
`timescale 1ns/1ps
`default_nettype none
module spei_store (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Access ports
  spei_mem_if.mem mp
);
  import spei_pkg::*;

  logic [VAL_W-1:0] mem_q [NUM_LOC];

  // Write port
  always_ff @(posedge aclk) begin
    if (mp.we && (mp.waddr <= IDX_MAX)) begin
      mem_q[mp.waddr] <= mp.wdata;
    end
  end

  // Registered reads; out-of-range addresses read zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mp.rdata_a <= '0;
      mp.rdata_b <= '0;
    end else begin
      mp.rdata_a <= (mp.raddr_a <= IDX_MAX) ? mem_q[mp.raddr_a] : '0;
      mp.rdata_b <= (mp.raddr_b <= IDX_MAX) ? mem_q[mp.raddr_b] : '0;
    end
  end
endmodule : spei_store
`default_nettype wire

// ===== design/spei_top.sv
// Purpose: Front-panel setpoint entry, mirror refresh, DAC feed, actuation
// Assumes: Switches synchronous to aclk
// Notes: Long counts are parameters
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE_01: Selector off powers panel down; index and value cannot change.
// RULE_02: Entering position one shows 88 and drives test point to 5.000 V.
// RULE_03: Position one up/down steps index 00..99 on the display.
// RULE_04: Test point shows the stored value at the selected index.
// RULE_05: Position two up/down adjusts tuning value in 1 mV steps.
// RULE_06: Holding up/down beyond two seconds speeds up the adjustment.
// RULE_07: Push-button stores adjusted value at selected index.
// RULE_08: Arithmetic core reads its setpoints from the shared RAM each cycle.
// RULE_09: Mirror copy into shared RAM only while core asserts release.
// RULE_10: Position nine starts input converter self-calibration.
// RULE_11: Position eight enables offset trim, position seven gain trim.
// RULE_12: Positions three, four, five preset value to +10 V, 0 V, -10 V.
// RULE_13: Core output word is serialised to the converters.
// RULE_14: Each serial word carries a 16-bit conversion code.
// RULE_15: Trip output low when untripped, high during partial trip.
// RULE_16: Four actuation channels with complementary pairs, selectable polarity.
// RULE_17: Channel lamp lit whenever its sink-side output conducts.
// RULE_18: Input converters self-calibrate automatically after power-up.
// RULE_19: Index saturates at 00 going down and 99 going up.
// RULE_20: Push-button ignored outside the set-value position.
module spei_top #(
  parameter int unsigned HOLD_ACCEL_CYC_P = spei_pkg::HOLD_ACCEL_CYC,
  parameter int unsigned REPEAT_SLOW_CYC_P = spei_pkg::REPEAT_SLOW_CYC,
  parameter int unsigned REPEAT_FAST_CYC_P = spei_pkg::REPEAT_FAST_CYC,
  parameter int unsigned SEGTEST_CYC_P = spei_pkg::SEGTEST_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [spei_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [spei_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Operator controls
  input wire logic [3:0] selector,
  input wire logic sw_up,
  input wire logic sw_down,
  input wire logic push_button,
  // Panel display and test point
  output logic setpoint_panel_power,
  output logic [3:0] disp_tens,
  output logic [3:0] disp_ones,
  output logic [spei_pkg::VAL_W-1:0] test_voltmeter_mv,
  // Calibration controls
  output logic adc_cal_start,
  output logic dac_offset_trim_en,
  output logic dac_gain_trim_en,
  // Arithmetic core side
  input wire logic shared_ram_release,
  input wire logic [spei_pkg::IDX_W-1:0] core_rd_addr,
  output logic [spei_pkg::VAL_W-1:0] core_rd_data,
  input wire logic [spei_pkg::VAL_W-1:0] core_out_word,
  input wire logic core_out_valid,
  output logic core_out_ready,
  input wire logic [spei_pkg::NUM_CH-1:0] core_partial_trip,
  // Serial converter feed
  output logic dac_sclk,
  output logic dac_sdata,
  output logic dac_sync_n,
  // Actuation outputs
  output logic [spei_pkg::NUM_CH-1:0] trip_out,
  output logic [spei_pkg::NUM_CH-1:0] normally_energized_out,
  output logic [spei_pkg::NUM_CH-1:0] normally_deenergized_out,
  output logic [spei_pkg::NUM_CH-1:0] channel_lamp
);
  import spei_pkg::*;

  spei_mem_if nvm_if ();
  spei_mem_if mir_if ();

  logic [3:0] sel_q;
  logic panel_on;
  logic sel_entered;
  logic step_q;
  logic dir_up_q;
  logic held;
  logic held_q;
  logic [31:0] hold_cnt_q;
  logic [31:0] rep_cnt_q;
  logic [31:0] seg_cnt_q;
  logic [IDX_W-1:0] index_q;
  logic signed [VAL_W-1:0] value_q;
  logic load_stored_q;
  logic btn_q;
  logic [IDX_W-1:0] walk_q;
  logic [IDX_W-1:0] walk_wr_q;
  logic walk_rd_q;
  logic rst_cal_q;
  logic sw_cal_q;
  logic [NUM_CH-1:0] pol_q;
  spei_ser_type ser_q;
  logic [VAL_W-1:0] shreg_q;
  logic [4:0] bit_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [NUM_CH-1:0] sink_on;

  spei_store u_nvm (.aclk(aclk), .aresetn(aresetn), .mp(nvm_if.mem));
  spei_store u_mirror (.aclk(aclk), .aresetn(aresetn), .mp(mir_if.mem));

  // Selector tracking
  assign panel_on = (selector != SEL_OFF); // [RULE_01]
  assign sel_entered = (selector != sel_q);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_q <= SEL_OFF;
      setpoint_panel_power <= 1'b0;
    end else begin
      sel_q <= selector;
      setpoint_panel_power <= panel_on; // [RULE_01]
    end
  end

  // Up/down hold timing
  assign held = panel_on && (sw_up ^ sw_down);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held_q <= 1'b0;
      hold_cnt_q <= '0;
      rep_cnt_q <= '0;
      step_q <= 1'b0;
      dir_up_q <= 1'b0;
    end else begin
      held_q <= held;
      dir_up_q <= sw_up;
      step_q <= 1'b0;
      if (!held) begin
        hold_cnt_q <= '0;
        rep_cnt_q <= '0;
      end else begin
        if (hold_cnt_q < HOLD_ACCEL_CYC_P) begin
          hold_cnt_q <= hold_cnt_q + 32'h1;
        end
        if (!held_q || (rep_cnt_q == '0)) begin
          step_q <= 1'b1;
          // Faster repeat once held past the acceleration time [RULE_06]
          rep_cnt_q <= (hold_cnt_q >= HOLD_ACCEL_CYC_P) ? REPEAT_FAST_CYC_P - 32'h1
                                                        : REPEAT_SLOW_CYC_P - 32'h1;
        end else begin
          rep_cnt_q <= rep_cnt_q - 32'h1;
        end
      end
    end
  end

  // Segment test timer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seg_cnt_q <= '0;
    end else if (sel_entered && (selector == SEL_READ)) begin
      seg_cnt_q <= SEGTEST_CYC_P; // [RULE_02]
    end else if ((seg_cnt_q != '0) && (selector == SEL_READ)) begin
      seg_cnt_q <= seg_cnt_q - 32'h1;
    end else if (selector != SEL_READ) begin
      seg_cnt_q <= '0;
    end
  end

  // Index counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      index_q <= IDX_MIN;
    end else if (step_q && panel_on && (selector == SEL_READ)) begin // [RULE_03]
      if (dir_up_q && (index_q != IDX_MAX)) begin
        index_q <= index_q + 7'h01; // [RULE_19]
      end else if (!dir_up_q && (index_q != IDX_MIN)) begin
        index_q <= index_q - 7'h01; // [RULE_19]
      end
    end
  end

  // Tuning value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value_q <= MV_ZERO;
      load_stored_q <= 1'b0;
    end else begin
      load_stored_q <= sel_entered && (selector == SEL_SET) && (sel_q == SEL_READ);
      if (load_stored_q) begin
        value_q <= nvm_if.rdata_a;
      end else if (sel_entered && (selector == SEL_FSH)) begin
        value_q <= MV_FSH; // [RULE_12]
      end else if (sel_entered && (selector == SEL_ZERO)) begin
        value_q <= MV_ZERO; // [RULE_12]
      end else if (sel_entered && (selector == SEL_FSL)) begin
        value_q <= MV_FSL; // [RULE_12]
      end else if (step_q && panel_on && (selector == SEL_SET)) begin // [RULE_05]
        // Clamped to the converter full scale
        if (dir_up_q && (value_q < MV_FSH)) begin
          value_q <= value_q + MV_STEP;
        end else if (!dir_up_q && (value_q > MV_FSL)) begin
          value_q <= value_q - MV_STEP;
        end
      end
    end
  end

  // Push-button edge commits value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      btn_q <= 1'b0;
    end else begin
      btn_q <= push_button;
    end
  end
  assign nvm_if.we = push_button && !btn_q && (selector == SEL_SET); // [RULE_07] [RULE_20]
  assign nvm_if.waddr = index_q; // [RULE_07]
  assign nvm_if.wdata = value_q;
  assign nvm_if.raddr_a = index_q; // [RULE_04]
  assign nvm_if.raddr_b = walk_q;

  // Display and test point
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      disp_tens <= '0;
      disp_ones <= '0;
      test_voltmeter_mv <= '0;
    end else if (!panel_on) begin
      disp_tens <= '0;
      disp_ones <= '0;
      test_voltmeter_mv <= '0;
    end else if ((selector == SEL_READ) && (sel_entered || (seg_cnt_q != '0))) begin
      disp_tens <= DIGIT_EIGHT; // [RULE_02]
      disp_ones <= DIGIT_EIGHT;
      test_voltmeter_mv <= MV_SEGTEST; // [RULE_02]
    end else begin
      disp_tens <= 4'(index_q / 7'h0A); // [RULE_03]
      disp_ones <= 4'(index_q % 7'h0A);
      if (selector == SEL_READ) begin
        test_voltmeter_mv <= nvm_if.rdata_a; // [RULE_04]
      end else begin
        test_voltmeter_mv <= value_q;
      end
    end
  end

  // Mirror walk; write needs release too, so a withdrawn
  // release never lands a stale word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      walk_q <= IDX_MIN;
      walk_wr_q <= IDX_MIN;
      walk_rd_q <= 1'b0;
    end else begin
      walk_rd_q <= shared_ram_release; // [RULE_09]
      walk_wr_q <= walk_q;
      if (shared_ram_release) begin
        walk_q <= (walk_q == IDX_MAX) ? IDX_MIN : walk_q + 7'h01;
      end
    end
  end
  assign mir_if.we = walk_rd_q && shared_ram_release; // [RULE_09]
  assign mir_if.waddr = walk_wr_q;
  assign mir_if.wdata = nvm_if.rdata_b;
  assign mir_if.raddr_a = core_rd_addr; // [RULE_08]
  assign mir_if.raddr_b = IDX_MIN;
  assign core_rd_data = mir_if.rdata_a;

  // Calibration start pulse and trim enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_cal_q <= 1'b1;
      adc_cal_start <= 1'b0;
      dac_offset_trim_en <= 1'b0;
      dac_gain_trim_en <= 1'b0;
    end else begin
      rst_cal_q <= 1'b0;
      adc_cal_start <= rst_cal_q || sw_cal_q // [RULE_18]
                       || (sel_entered && (selector == SEL_CAL)); // [RULE_10]
      dac_offset_trim_en <= (selector == SEL_OFFS); // [RULE_11]
      dac_gain_trim_en <= (selector == SEL_GAIN); // [RULE_11]
    end
  end

  // Serializer: 16-bit word, MSB first, data changes on falling sclk
  assign core_out_ready = (ser_q == SER_IDLE); // [RULE_13]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ser_q <= SER_IDLE;
      shreg_q <= '0;
      bit_q <= '0;
      dac_sclk <= 1'b0;
      dac_sdata <= 1'b0;
      dac_sync_n <= 1'b1;
    end else begin
      case (ser_q)
        SER_IDLE: begin
          dac_sclk <= 1'b0;
          if (core_out_valid) begin
            shreg_q <= {core_out_word[VAL_W-2:0], 1'b0}; // [RULE_13]
            dac_sdata <= core_out_word[VAL_W-1];
            bit_q <= '0;
            dac_sync_n <= 1'b0;
            ser_q <= SER_SHIFT;
          end
        end
        SER_SHIFT: begin
          dac_sclk <= !dac_sclk;
          if (dac_sclk) begin
            if (bit_q == DAC_LAST) begin // [RULE_14]
              dac_sync_n <= 1'b1;
              ser_q <= SER_IDLE;
            end else begin
              bit_q <= bit_q + 5'h01;
              dac_sdata <= shreg_q[VAL_W-1];
              shreg_q <= {shreg_q[VAL_W-2:0], 1'b0};
            end
          end
        end
        default: begin
          ser_q <= SER_IDLE;
        end
      endcase
    end
  end

  // Actuation: polarity bit 1 selects normally energized sink
  always_comb begin
    sink_on = pol_q ^ trip_out; // [RULE_16]
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trip_out <= '0;
      normally_energized_out <= '0;
      normally_deenergized_out <= '0;
      channel_lamp <= '0;
    end else begin
      trip_out <= core_partial_trip; // [RULE_15]
      normally_energized_out <= sink_on; // [RULE_16]
      normally_deenergized_out <= ~sink_on; // [RULE_16]
      channel_lamp <= sink_on; // [RULE_17]
    end
  end

  // AXI4-Lite write, either order
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      pol_q <= CTRL_POL_RST;
      sw_cal_q <= 1'b0;
    end else begin
      sw_cal_q <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_hold_q && w_hold_q && !s_axi_bvalid) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_q == REG_CTRL) begin
          s_axi_bresp <= RESP_OKAY;
          if (wstrb_q[0]) begin
            pol_q <= wdata_q[NUM_CH-1:0];
            sw_cal_q <= wdata_q[CTRL_CAL_BIT]; // Self-clearing request
          end
        end else if ((awaddr_q == REG_STATUS) || (awaddr_q == REG_TRIP)) begin
          s_axi_bresp <= RESP_OKAY; // Read-only, write ignored
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read: one-cycle answer from live state
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL: s_axi_rdata <= {28'h0000000, pol_q};
        REG_STATUS: s_axi_rdata <= {value_q, 5'h00, index_q, selector};
        REG_TRIP: s_axi_rdata <= {24'h000000, channel_lamp, trip_out};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : spei_top
`default_nettype wire

// ===== dv/setpoint_entry_interface_test.sv
// Purpose: Self-checking bench
// Assumes: Short timing parameters
// Notes: Waits are bounded
`timescale 1ns/1ps
`default_nettype none
module setpoint_entry_interface_test;
  import spei_pkg::*;
  // Port nets
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rx;
  logic [3:0] s_axi_wstrb, selector, disp_tens, disp_ones;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic sw_up, sw_down, push_button, setpoint_panel_power, adc_cal_start;
  logic dac_offset_trim_en, dac_gain_trim_en, shared_ram_release, core_out_valid;
  logic core_out_ready, dac_sclk, dac_sdata, dac_sync_n, sclk_q;
  logic [6:0] core_rd_addr;
  logic [15:0] test_voltmeter_mv, core_rd_data, core_out_word;
  logic [3:0] core_partial_trip, trip_out, normally_energized_out;
  logic [3:0] normally_deenergized_out, channel_lamp;
  logic [3:0] pp[3] = '{SEL_FSH, SEL_ZERO, SEL_FSL};
  logic [15:0] pv[3] = '{MV_FSH, MV_ZERO, MV_FSL};
  int nb = 0;
  int n_mismatch = 0;
  int n_tests = 0;
  spei_top #(.HOLD_ACCEL_CYC_P(40), .REPEAT_SLOW_CYC_P(8), .REPEAT_FAST_CYC_P(2),
    .SEGTEST_CYC_P(10)) uut (.*);
  spei_op_model op (.*);
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic end_sim();
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic tmo();
    n_mismatch++;
    $display("wrong value at %0t: wait timed out", $time);
    end_sim();
  endtask : tmo
  // Bus master
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 50) tmo();
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 50) tmo();
  endtask : axi_rd
  // Status field checks
  task automatic ix(input logic [6:0] i);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(REG_STATUS, d, r);
    chk(d[10:0], {i, selector});
  endtask : ix
  task automatic vl(input logic [15:0] v);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(REG_STATUS, d, r);
    chk(d[31:16], v);
  endtask : vl
  task automatic send(input logic [15:0] w);
    int n;
    @(posedge aclk);
    core_out_word <= w;
    core_out_valid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (core_out_ready) break;
    end
    core_out_valid <= 1'b0;
    if (n == 50) tmo();
  endtask : send
  // Converter: sample on sclk rise
  always @(posedge aclk) begin
    sclk_q <= dac_sclk;
    if (dac_sclk && !sclk_q && !dac_sync_n) begin
      rx <= {rx[30:0], dac_sdata};
      nb <= nb + 1;
    end
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int n;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, shared_ram_release, core_out_valid, sclk_q} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, core_out_word, core_partial_trip} = '0;
    s_axi_wstrb = 4'hF;
    core_rd_addr = 7'h63;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1 chk(adc_cal_start, 1'b1);
    axi_rd(REG_CTRL, d, r);
    chk({setpoint_panel_power, d[3:0]}, {1'b0, CTRL_POL_RST});
    op.hold(1'b1, 20);
    ix(7'h00);
    op.turn(SEL_READ, 4);
    chk({disp_tens, disp_ones, test_voltmeter_mv}, {8'h88, MV_SEGTEST});
    repeat (15) @(posedge aclk);
    op.hold(1'b0, 3);
    ix(7'h00);
    repeat (3) op.hold(1'b1, 3);
    ix(7'h03);
    op.hold(1'b1, 400);
    op.hold(1'b1, 3);
    ix(7'h63);
    chk({disp_tens, disp_ones}, 8'h99);
    for (n = 0; n < 3; n++) begin
      op.turn(pp[n], 4);
      vl(pv[n]);
    end
    op.press();
    op.turn(SEL_ZERO, 4);
    op.turn(SEL_SET, 4);
    repeat (2) op.hold(1'b1, 3);
    vl(16'h0002);
    op.hold(1'b1, 100);
    axi_rd(REG_STATUS, d, r);
    chk(d[31:16] inside {[16'h001B:16'h002F]}, 1'b1);
    op.turn(SEL_FSH, 4);
    op.turn(SEL_SET, 4);
    op.press();
    op.turn(SEL_FSL, 4);
    op.press();
    op.turn(SEL_READ, 30);
    chk({setpoint_panel_power, test_voltmeter_mv}, {1'b1, MV_FSH});
    chk(core_rd_data !== MV_FSH, 1'b1);
    shared_ram_release <= 1'b1;
    repeat (250) @(posedge aclk);
    chk(core_rd_data, MV_FSH);
    op.turn(SEL_GAIN, 4);
    chk({dac_gain_trim_en, dac_offset_trim_en}, 2'b10);
    op.turn(SEL_OFFS, 4);
    chk({dac_gain_trim_en, dac_offset_trim_en}, 2'b01);
    op.turn(SEL_CAL, 0);
    for (n = 0; n < 6 && adc_cal_start !== 1'b1; n++) @(posedge aclk);
    chk(n < 6, 1'b1);
    axi_wr(REG_CTRL, 32'h0000_0005, r);
    chk(r, RESP_OKAY);
    core_partial_trip <= 4'h3;
    repeat (2) @(posedge aclk);
    axi_rd(REG_TRIP, d, r);
    chk(d[7:0], 8'h63);
    chk({normally_deenergized_out, trip_out}, 8'h93);
    axi_wr(8'h0C, 32'h0000_FFFF, r);
    chk(r, RESP_SLVERR);
    axi_rd(8'h0C, d, r);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR});
    send(16'hA5C3);
    send(16'h3C5A);
    repeat (40) @(posedge aclk);
    chk(rx, 32'hA5C3_3C5A);
    chk(nb, 32);
    end_sim();
  end
endmodule : setpoint_entry_interface_test
`default_nettype wire

// ===== dv/spei_op_model.sv
// Purpose: Operator model
// Assumes: No bounce
// Notes: Idle time lets the panel settle
`timescale 1ns/1ps
`default_nettype none
module spei_op_model (
  // Clock
  input wire logic aclk,
  // Operator controls
  output logic [3:0] selector,
  output logic sw_up,
  output logic sw_down,
  output logic push_button
);
  // Switches idle at power-up
  initial begin
    selector = 4'h0;
    sw_up = 1'b0;
    sw_down = 1'b0;
    push_button = 1'b0;
  end
  task automatic turn(input logic [3:0] p, input int n);
    @(posedge aclk);
    selector <= p;
    repeat (n) @(posedge aclk);
  endtask : turn
  // Three held cycles give exactly one step
  task automatic hold(input logic u, input int n);
    @(posedge aclk);
    sw_up <= u;
    sw_down <= !u;
    repeat (n) @(posedge aclk);
    sw_up <= 1'b0;
    sw_down <= 1'b0;
    repeat (12) @(posedge aclk);
  endtask : hold
  task automatic press();
    @(posedge aclk);
    push_button <= 1'b1;
    repeat (3) @(posedge aclk);
    push_button <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : press
endmodule : spei_op_model
`default_nettype wire

// ===== dv/spei_top_properties.sv
// Purpose: Port checks
// Assumes: One clock
// Notes: Bound into spei_top
`timescale 1ns/1ps
`default_nettype none
module spei_top_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Panel and calibration
  input wire logic [3:0] selector,
  input wire logic [3:0] disp_tens,
  input wire logic [3:0] disp_ones,
  input wire logic [spei_pkg::VAL_W-1:0] test_voltmeter_mv,
  input wire logic adc_cal_start,
  input wire logic dac_offset_trim_en,
  input wire logic dac_gain_trim_en,
  // Core word and serial feed
  input wire logic [spei_pkg::VAL_W-1:0] core_out_word,
  input wire logic core_out_valid,
  input wire logic core_out_ready,
  input wire logic dac_sclk,
  input wire logic dac_sdata,
  input wire logic dac_sync_n,
  // Actuation
  input wire logic [spei_pkg::NUM_CH-1:0] core_partial_trip,
  input wire logic [spei_pkg::NUM_CH-1:0] trip_out,
  input wire logic [spei_pkg::NUM_CH-1:0] normally_energized_out,
  input wire logic [spei_pkg::NUM_CH-1:0] normally_deenergized_out,
  input wire logic [spei_pkg::NUM_CH-1:0] channel_lamp
);
  import spei_pkg::*;
  // One clock
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Segment test on entry
  property p_seg;
    selector == SEL_READ && $past(selector) != SEL_READ |-> ##2 disp_tens == DIGIT_EIGHT
      && disp_ones == DIGIT_EIGHT && test_voltmeter_mv == MV_SEGTEST;
  endproperty
  a_seg: assert property (p_seg) else $error("segment test missing");
  property p_cal;
    selector == SEL_CAL && $past(selector) != SEL_CAL |-> ##[0:3] adc_cal_start;
  endproperty
  a_cal: assert property (p_cal) else $error("calibration not started");
  // Trim enables follow the selector
  property p_trim;
    $past(selector) == $past(selector, 2) |->
      dac_offset_trim_en == ($past(selector) == SEL_OFFS)
      && dac_gain_trim_en == ($past(selector) == SEL_GAIN);
  endproperty
  a_trim: assert property (p_trim) else $error("trim enable wrong");
  // A frame is sixteen two-cycle bits
  property p_frame;
    $fell(dac_sync_n) |-> ##31 !dac_sync_n ##1 dac_sync_n;
  endproperty
  a_frame: assert property (p_frame) else $error("frame length wrong");
  property p_msb;
    core_out_valid && core_out_ready |=> !dac_sync_n && !dac_sclk
      && dac_sdata == $past(core_out_word[15]);
  endproperty
  a_msb: assert property (p_msb) else $error("first serial bit wrong");
  property p_busy;
    !dac_sync_n |-> !core_out_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("ready during frame");
  // Skip the first edge after reset
  property p_pair;
    $past(aresetn) |-> channel_lamp == normally_energized_out
      && normally_deenergized_out == ~normally_energized_out;
  endproperty
  a_pair: assert property (p_pair) else $error("output pair wrong");
  property p_trip;
    $past(aresetn) |-> trip_out == $past(core_partial_trip);
  endproperty
  a_trip: assert property (p_trip) else $error("trip output wrong");
endmodule : spei_top_chk
bind spei_top spei_top_chk u_chk (.*);
`default_nettype wire
